// ---- verilog/rtop_pkg.sv ----
package rtop_pkg;

  // register addresses on the special function register port
  localparam logic [15:0] RTOP_ADDR_BUF_LO = 16'hFF0E;
  localparam logic [15:0] RTOP_ADDR_BUF_HI = 16'hFF0F;
  localparam logic [15:0] RTOP_ADDR_LATCH  = 16'hFF00;
  localparam logic [15:0] RTOP_ADDR_DIR    = 16'hFF20;
  localparam logic [15:0] RTOP_ADDR_CTRL   = 16'hFF01;

  // control register field positions
  localparam int RTOP_CTRL_LO_EN    = 0;
  localparam int RTOP_CTRL_HI_EN    = 1;
  localparam int RTOP_CTRL_BYTE     = 2;
  localparam int RTOP_CTRL_EXT_EN   = 3;
  localparam int RTOP_CTRL_EXT_ONLY = 4;
  localparam logic [7:0] RTOP_CTRL_MASK  = 8'h1F;

  // reset values
  localparam logic [7:0] RTOP_CTRL_RESET = 8'h00;
  localparam logic [7:0] RTOP_DIR_RESET  = 8'hFF;  // 1 = input, so pins float
  localparam logic [7:0] RTOP_ZERO8      = 8'h00;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_idx;
    logic        bit_val;
    logic [7:0]  wdata;
  } rtop_req_t;

  // whole block state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] dir;
    logic [7:0] latch;
    logic [3:0] buf_lo;
    logic [3:0] buf_hi;
    logic [7:0] oe;
    logic [7:0] rdata;
    logic       rvalid;
    logic [2:0] trig_prev;
  } rtop_state_t;

endpackage : rtop_pkg

// ---- verilog/rtop_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtop_top
  import rtop_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // special function register port
  input  wire logic [15:0] SFR_ADDR,
  input  wire logic        SFR_WR,
  input  wire logic        SFR_RD,
  input  wire logic        SFR_BIT_OP,
  input  wire logic [2:0]  SFR_BIT_IDX,
  input  wire logic        SFR_BIT_VAL,
  input  wire logic [7:0]  SFR_WDATA,
  output logic      [7:0]  SFR_RDATA,
  output logic             SFR_RVALID,
  // transfer triggers from on-chip timer and interrupt logic
  input  wire logic        CMP_FIRST_IRQ,
  input  wire logic        CMP_SECOND_IRQ,
  input  wire logic        EXT_IRQ_FIRST,
  // port pins
  output logic      [7:0]  PORT_OUT,
  output logic      [7:0]  PORT_OE
);

  rtop_state_t s_q;
  rtop_state_t s_d;
  rtop_req_t   req;
  logic        lo_en;
  logic        hi_en;
  logic        mode8;
  logic [2:0]  trig_now;
  logic [2:0]  trig_rise;
  logic        lo_trig;
  logic        hi_trig;
  logic [7:0]  cur_val;
  logic [7:0]  wr_val;

  // gather the register port into one request
  assign req = '{addr: SFR_ADDR, wr: SFR_WR, rd: SFR_RD, bit_op: SFR_BIT_OP,
                 bit_idx: SFR_BIT_IDX, bit_val: SFR_BIT_VAL, wdata: SFR_WDATA};

  assign lo_en = s_q.ctrl[RTOP_CTRL_LO_EN];
  assign hi_en = s_q.ctrl[RTOP_CTRL_HI_EN];
  // 8-bit channel needs byte bit and both nibbles
  assign mode8 = s_q.ctrl[RTOP_CTRL_BYTE] & lo_en & hi_en;

  // rising edges so a held trigger moves data once
  assign trig_now  = {EXT_IRQ_FIRST, CMP_SECOND_IRQ, CMP_FIRST_IRQ};
  assign trig_rise = trig_now & ~s_q.trig_prev;

  // low-side trigger picked by the external bits
  always_comb begin
    if (s_q.ctrl[RTOP_CTRL_EXT_ONLY] && s_q.ctrl[RTOP_CTRL_EXT_EN]) begin
      lo_trig = trig_rise[2];
    end else if (s_q.ctrl[RTOP_CTRL_EXT_EN]) begin
      lo_trig = trig_rise[0] | trig_rise[2];
    end else begin
      lo_trig = trig_rise[0];
    end
  end

  // high nibble follows second match, or low trigger in 8-bit mode
  assign hi_trig = mode8 ? lo_trig : trig_rise[1];

  // current value of the addressed register, shared by reads and bit ops
  always_comb begin
    case (req.addr)
      // port reads always show the latch
      RTOP_ADDR_LATCH:  cur_val = s_q.latch;
      RTOP_ADDR_DIR:    cur_val = s_q.dir;
      RTOP_ADDR_CTRL:   cur_val = s_q.ctrl;
      // both buffer addresses read high over low
      RTOP_ADDR_BUF_LO: cur_val = {s_q.buf_hi, s_q.buf_lo};
      RTOP_ADDR_BUF_HI: cur_val = {s_q.buf_hi, s_q.buf_lo};
      default:          cur_val = RTOP_ZERO8;
    endcase
  end

  // a bit op rewrites the whole byte around the chosen bit
  always_comb begin
    wr_val = req.wdata;
    if (req.bit_op) begin
      wr_val = cur_val;
      wr_val[req.bit_idx] = req.bit_val;
    end
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.trig_prev = trig_now;
    s_d.rvalid    = req.rd;
    s_d.rdata     = req.rd ? cur_val : s_q.rdata;
    if (req.wr) begin
      case (req.addr)
        RTOP_ADDR_LATCH: begin
          // real-time nibbles ignore software port writes
          if (!lo_en) s_d.latch[3:0] = wr_val[3:0];
          if (!hi_en) s_d.latch[7:4] = wr_val[7:4];
        end
        RTOP_ADDR_DIR:  s_d.dir  = wr_val;
        // control register byte or bit writes
        RTOP_ADDR_CTRL: s_d.ctrl = wr_val & RTOP_CTRL_MASK;
        // low buffer sits at the lower address
        RTOP_ADDR_BUF_LO: begin
          s_d.buf_lo = wr_val[3:0];
          if (mode8) s_d.buf_hi = wr_val[7:4];
        end
        RTOP_ADDR_BUF_HI: begin
          // separate channels keep the other nibble
          s_d.buf_hi = wr_val[7:4];
          if (mode8) s_d.buf_lo = wr_val[3:0];
        end
        default: s_d = s_d;  // unmapped addresses change nothing
      endcase
    end
    // hardware transfer takes the buffers as they stood
    if (lo_en && lo_trig) s_d.latch[3:0] = s_q.buf_lo;
    if (hi_en && hi_trig) s_d.latch[7:4] = s_q.buf_hi;
    // enable bit forces the nibble drivers on over direction
    s_d.oe[3:0] = s_d.ctrl[RTOP_CTRL_LO_EN] ? 4'hF : ~s_d.dir[3:0];
    s_d.oe[7:4] = s_d.ctrl[RTOP_CTRL_HI_EN] ? 4'hF : ~s_d.dir[7:4];
    if (RST) begin
      s_d.ctrl      = RTOP_CTRL_RESET;
      // all pins released; latch and buffers kept as they are
      s_d.dir       = RTOP_DIR_RESET;
      s_d.oe        = RTOP_ZERO8;
      s_d.rdata     = RTOP_ZERO8;
      s_d.rvalid    = 1'b0;
      s_d.trig_prev = 3'h0;
      s_d.latch     = s_q.latch;
      s_d.buf_lo    = s_q.buf_lo;
      s_d.buf_hi    = s_q.buf_hi;
    end
  end

  // single state register; reset is folded into the next-state logic
  always_ff @(posedge CLK_SYS) begin
    s_q <= s_d;
  end

  assign PORT_OUT   = s_q.latch;
  assign PORT_OE    = s_q.oe;
  assign SFR_RDATA  = s_q.rdata;
  assign SFR_RVALID = s_q.rvalid;

  ctrl_reset_a: assert property (@(posedge CLK_SYS) $fell(RST) |-> s_q.ctrl == RTOP_CTRL_RESET)
    else $error("control register not cleared by reset");

  pins_float_a: assert property (@(posedge CLK_SYS) $fell(RST) |-> PORT_OE == RTOP_ZERO8)
    else $error("pins driven after reset");

  // enabled nibble drives regardless of direction
  oe_override_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    lo_en |-> PORT_OE[3:0] == 4'hF)
    else $error("low nibble not driven in real-time mode");

  lo_xfer_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    lo_en && lo_trig |=> PORT_OUT[3:0] == $past(s_q.buf_lo))
    else $error("low buffer not moved to latch");

  // high nibble on second match in 4-bit mode
  hi_xfer_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    hi_en && !mode8 && CMP_SECOND_IRQ && !s_q.trig_prev[1] |=> PORT_OUT[7:4] == $past(s_q.buf_hi))
    else $error("high buffer not moved on second match");

  // port write blocked for real-time nibble
  latch_guard_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_WR && SFR_ADDR == RTOP_ADDR_LATCH && hi_en && !hi_trig |=> PORT_OUT[7:4] == $past(PORT_OUT[7:4]))
    else $error("software changed a real-time nibble");

  // separate channel write keeps other buffer
  buf_sep_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_WR && SFR_ADDR == RTOP_ADDR_BUF_LO && !mode8 |=> s_q.buf_hi == $past(s_q.buf_hi))
    else $error("low buffer write disturbed high buffer");

  buf_byte_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_WR && !SFR_BIT_OP && SFR_ADDR == RTOP_ADDR_BUF_HI && mode8 |=> s_q.buf_lo == $past(SFR_WDATA[3:0]))
    else $error("8-bit write did not fill low buffer");

  buf_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_RD && SFR_ADDR == RTOP_ADDR_BUF_LO |=> SFR_RVALID && SFR_RDATA == $past({s_q.buf_hi, s_q.buf_lo}))
    else $error("buffer read has wrong layout");

  // real-time low nibble ignores port writes
  latch_lo_guard_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_WR && SFR_ADDR == RTOP_ADDR_LATCH && lo_en && !lo_trig |=> PORT_OUT[3:0] == $past(PORT_OUT[3:0]))
    else $error("software changed the real-time low nibble");

  held_trig_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CMP_FIRST_IRQ && s_q.trig_prev[0] && !s_q.ctrl[RTOP_CTRL_EXT_EN] && !(SFR_WR && SFR_ADDR == RTOP_ADDR_LATCH)
    |=> PORT_OUT[3:0] == $past(PORT_OUT[3:0]))
    else $error("held trigger moved low nibble again");

  latch_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_RD && SFR_ADDR == RTOP_ADDR_LATCH |=> SFR_RDATA == $past(PORT_OUT))
    else $error("port read did not return the latch");

  ctrl_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_WR && !SFR_BIT_OP && SFR_ADDR == RTOP_ADDR_CTRL |=> s_q.ctrl == ($past(SFR_WDATA) & RTOP_CTRL_MASK))
    else $error("control byte write lost");

  ext_xfer_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_q.ctrl[RTOP_CTRL_EXT_EN] && lo_en && EXT_IRQ_FIRST && !s_q.trig_prev[2] |=> PORT_OUT[3:0] == $past(s_q.buf_lo))
    else $error("external trigger did not move low buffer");

  oe_hi_override_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    hi_en |-> PORT_OE[7:4] == 4'hF)
    else $error("high nibble not driven in real-time mode");

  byte_xfer_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    mode8 && lo_trig |=> PORT_OUT[7:4] == $past(s_q.buf_hi))
    else $error("8-bit transfer missed the high nibble");

endmodule : rtop_top
`default_nettype wire

// ---- verif/rtop_load_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtop_load_model (
  // clock and pins
  input  wire logic       clk,
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  // level the load sees
  output logic      [7:0] pin_level
);
  logic [7:0] last_q;
  assign pin_level = (port_oe & port_out) | (~port_oe & ~last_q);
  // floating bits flip each cycle so no stale value passes for data
  always_ff @(posedge clk) last_q <= pin_level;
endmodule : rtop_load_model
`default_nettype wire

// ---- verif/realtime_output_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module realtime_output_port_tb;
  import rtop_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, bop = 0, bval = 0;
  logic        rvld;
  logic [15:0] addr = 16'h0000;
  logic [2:0]  bidx = 3'h0, trig = 3'h0;
  logic [7:0]  wdata = 8'h00, rdata, pout, poe, pins;
  int          n_fail = 0, total_checks = 0;
  always #2 clk = ~clk;
  rtop_top i_rtop_top (.CLK_SYS(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_BIT_OP(bop), .SFR_BIT_IDX(bidx), .SFR_BIT_VAL(bval), .SFR_WDATA(wdata),
    .SFR_RDATA(rdata), .SFR_RVALID(rvld), .CMP_FIRST_IRQ(trig[0]), .CMP_SECOND_IRQ(trig[1]),
    .EXT_IRQ_FIRST(trig[2]), .PORT_OUT(pout), .PORT_OE(poe));
  rtop_load_model i_rtop_load_model (.clk(clk), .port_out(pout), .port_oe(poe), .pin_level(pins));
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one-cycle write strobe, byte or bit
  task automatic wreg(input logic [15:0] a, input logic [7:0] d, input logic b = 0, input int i = 0);
    @(negedge clk);
    {wr, addr, wdata, bop, bidx, bval} = {1'b1, a, d, b, i[2:0], d[0]};
    @(negedge clk);
    {wr, bop} = 2'b00;
  endtask : wreg
  // read with the answer taken in the following cycle
  task automatic rreg(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 0;
    check("read data", rdata, exp);
    check("read valid", {7'h00, rvld}, 8'h01);
  endtask : rreg
  // single rising edge on one trigger input
  task automatic pulse(input int i);
    @(negedge clk);
    trig[i] = 1;
    @(negedge clk);
    trig[i] = 0;
    @(negedge clk);
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // watchdog, tests need well under a microsecond
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    rreg(RTOP_ADDR_CTRL, 8'h00);
    check("enables", poe, 8'h00);
    rreg(16'h0000, 8'h00);
    $display("test reset done");
    wreg(RTOP_ADDR_LATCH, 8'hA5);
    rreg(RTOP_ADDR_LATCH, 8'hA5);
    wreg(RTOP_ADDR_CTRL, 8'h01, 1, 0);
    rreg(RTOP_ADDR_CTRL, 8'h01);
    check("enables", poe, 8'h0F);
    check("pins", pins & 8'h0F, 8'h05);
    wreg(RTOP_ADDR_LATCH, 8'h00, 1, 7);
    rreg(RTOP_ADDR_LATCH, 8'h25);
    // high buffer first, so the low write meets a known high nibble
    wreg(RTOP_ADDR_BUF_HI, 8'hC0);
    wreg(RTOP_ADDR_BUF_LO, 8'h03);
    rreg(RTOP_ADDR_BUF_LO, 8'hC3);
    rreg(RTOP_ADDR_BUF_HI, 8'hC3);
    wreg(RTOP_ADDR_LATCH, 8'h00);
    rreg(RTOP_ADDR_LATCH, 8'h05);
    $display("test access done");
    @(negedge clk);
    trig[0] = 1;
    wreg(RTOP_ADDR_BUF_LO, 8'h09);
    trig[0] = 0;
    check("port", pout, 8'h03);
    pulse(0);
    check("port", pout, 8'h09);
    pulse(1);
    check("port", pout, 8'h09);
    wreg(RTOP_ADDR_CTRL, 8'h01, 1, 1);
    pulse(1);
    check("port", pout, 8'hC9);
    wreg(RTOP_ADDR_LATCH, 8'h00);
    check("port", pout, 8'hC9);
    $display("test nibble done");
    wreg(RTOP_ADDR_CTRL, 8'h07);
    wreg(RTOP_ADDR_BUF_HI, 8'h9A);
    pulse(1);
    check("port", pout, 8'hC9);
    pulse(0);
    check("port", pout, 8'h9A);
    check("pins", pins, 8'h9A);
    wreg(RTOP_ADDR_CTRL, 8'h0F);
    wreg(RTOP_ADDR_BUF_LO, 8'h5C);
    pulse(2);
    check("port", pout, 8'h5C);
    wreg(RTOP_ADDR_CTRL, 8'h1F);
    wreg(RTOP_ADDR_BUF_LO, 8'h3E);
    pulse(0);
    check("port", pout, 8'h5C);
    pulse(2);
    check("port", pout, 8'h3E);
    rreg(RTOP_ADDR_CTRL, 8'h1F);
    $display("test byte done");
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    check("enables", poe, 8'h00);
    rreg(RTOP_ADDR_CTRL, 8'h00);
    rreg(RTOP_ADDR_LATCH, 8'h3E);
    wreg(RTOP_ADDR_DIR, 8'hF0);
    check("enables", poe, 8'h0F);
    check("pins", pins & 8'h0F, 8'h0E);
    $display("test second reset done");
    print_verdict();
  end
endmodule : realtime_output_port_tb
`default_nettype wire
